// >>> fwps_defines.svh
`ifndef FWPS_DEFINES_SVH
`define FWPS_DEFINES_SVH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define FWPS_ADDR_W       18
`define FWPS_MEM_TOP      18'h3FFFF
`define FWPS_TOP_SECT_LO  18'h3F000
`define FWPS_BOT_SECT_HI  18'h00FFF
`define FWPS_SECT_LSB     12
`define FWPS_B32_LSB      15
`define FWPS_B64_LSB      16
`define FWPS_BP_Q1_LO     18'h30000
`define FWPS_BP_HALF_LO   18'h20000
`define FWPS_AAI_STEP     18'h00002

// ----------------------------------------------------------------------
// Command codes from the serial decoder
// ----------------------------------------------------------------------
`define FWPS_CMD_W        4
`define FWPS_CMD_NONE     4'h0
`define FWPS_CMD_WRITE_ENABLE_CMD     4'h1
`define FWPS_CMD_WRITE_DISABLE_CMD     4'h2
`define FWPS_CMD_STATUS_WRITE_CMD     4'h3
`define FWPS_CMD_BYTE     4'h4
`define FWPS_CMD_AAI      4'h5
`define FWPS_CMD_SECT     4'h6
`define FWPS_CMD_BLK32    4'h7
`define FWPS_CMD_BLK64    4'h8
`define FWPS_CMD_CHIP     4'h9

// ----------------------------------------------------------------------
// Status field positions and power-up values
// ----------------------------------------------------------------------
`define FWPS_SM_BUSY      0
`define FWPS_SM_WEL       1
`define FWPS_SM_BP_LO     2
`define FWPS_SM_BP_HI     3
`define FWPS_SM_AAI       6
`define FWPS_SM_BPL       7
`define FWPS_SL_TSP       2
`define FWPS_SL_BSP       3
`define FWPS_BP_RST       2'h3
`define FWPS_BPL_RST      1'h0
`define FWPS_SL_RST       1'h0

`endif

// >>> fwps_pkg.sv
`default_nettype none
`include "fwps_defines.svh"

package fwps_pkg;

    typedef enum logic [`FWPS_CMD_W-1:0] {
        FWPS_NONE  = `FWPS_CMD_NONE,
        FWPS_WRITE_ENABLE_CMD  = `FWPS_CMD_WRITE_ENABLE_CMD,
        FWPS_WRITE_DISABLE_CMD  = `FWPS_CMD_WRITE_DISABLE_CMD,
        FWPS_STATUS_WRITE_CMD  = `FWPS_CMD_STATUS_WRITE_CMD,
        FWPS_BYTE  = `FWPS_CMD_BYTE,
        FWPS_AAI   = `FWPS_CMD_AAI,
        FWPS_SECT  = `FWPS_CMD_SECT,
        FWPS_BLK32 = `FWPS_CMD_BLK32,
        FWPS_BLK64 = `FWPS_CMD_BLK64,
        FWPS_CHIP  = `FWPS_CMD_CHIP
    } fwps_cmd_e;

    typedef enum logic [1:0] {
        FWPS_IDLE = 2'h1,
        FWPS_BUSY = 2'h2
    } fwps_state_e;

    typedef logic [`FWPS_ADDR_W-1:0] fwps_addr_t;

    typedef struct packed {
        fwps_state_e st;
        logic        wp_s1;
        logic        wp_s2;
        logic        write_enable_latch;
        logic        aai_mode;
        logic [1:0]  block_protect;
        logic        protect_lock_bit;
        logic        top_sector_lock;
        logic        bottom_sector_lock;
        fwps_addr_t  aai_addr;
        logic        start;
        fwps_cmd_e   op;
        fwps_addr_t  op_addr;
        logic        refused;
        logic [7:0]  stat_main;
        logic [7:0]  stat_sect;
    } fwps_state_s;

endpackage

`default_nettype wire

// >>> fwps_range_check.sv
`default_nettype none
`include "fwps_defines.svh"

module fwps_range_check
    import fwps_pkg::*;
(
    input  wire fwps_cmd_e  op,
    input  wire fwps_addr_t addr,
    input  wire logic [1:0] block_protect,
    input  wire logic       top_sector_lock,
    input  wire logic       bottom_sector_lock,
    output logic            hit
);

    fwps_addr_t lo;
    fwps_addr_t hi;
    fwps_addr_t bp_lo;

    // ------------------------------------------------------------------
    // Target span of the operation
    // ------------------------------------------------------------------
    always_comb begin
        lo = addr;
        hi = addr;
        case (op)
            FWPS_AAI: begin
                lo = {addr[`FWPS_ADDR_W-1:1], 1'b0};
                hi = {addr[`FWPS_ADDR_W-1:1], 1'b1};
            end
            FWPS_SECT: begin
                lo = addr & ~fwps_addr_t'((1 << `FWPS_SECT_LSB) - 1);
                hi = addr | fwps_addr_t'((1 << `FWPS_SECT_LSB) - 1);
            end
            FWPS_BLK32: begin
                lo = addr & ~fwps_addr_t'((1 << `FWPS_B32_LSB) - 1);
                hi = addr | fwps_addr_t'((1 << `FWPS_B32_LSB) - 1);
            end
            FWPS_BLK64: begin
                lo = addr & ~fwps_addr_t'((1 << `FWPS_B64_LSB) - 1);
                hi = addr | fwps_addr_t'((1 << `FWPS_B64_LSB) - 1);
            end
            FWPS_CHIP: begin
                lo = '0;
                hi = `FWPS_MEM_TOP;
            end
            default: begin
                lo = addr;
                hi = addr;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Protected region checks
    // ------------------------------------------------------------------
    always_comb begin
        case (block_protect)
            2'h1:    bp_lo = `FWPS_BP_Q1_LO;
            2'h2:    bp_lo = `FWPS_BP_HALF_LO;
            default: bp_lo = '0;
        endcase
        hit = ((block_protect != 2'h0) && (hi >= bp_lo))
            || (top_sector_lock && (hi >= `FWPS_TOP_SECT_LO))
            || (bottom_sector_lock && (lo <= `FWPS_BOT_SECT_HI))
            || ((op == FWPS_CHIP) && (block_protect != 2'h0));
    end

endmodule

`default_nettype wire

// >>> fwps_status_ctrl.sv
`default_nettype none
`include "fwps_defines.svh"

module fwps_status_ctrl
    import fwps_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       wp_n,
    input  wire logic       cmd_valid,
    input  wire fwps_cmd_e  cmd_code,
    input  wire fwps_addr_t cmd_addr,
    input  wire logic [7:0] cmd_data,
    input  wire logic       cmd_data1_valid,
    input  wire logic [7:0] cmd_data1,
    input  wire logic       op_done,
    output logic [7:0]      status_main,
    output logic [7:0]      sector_lock_status,
    output logic            op_start,
    output fwps_cmd_e       op_code,
    output fwps_addr_t      op_addr,
    output logic            op_refused
);

    fwps_state_s q;
    fwps_state_s d;
    logic        cmd_hit;
    logic        next_hit;
    fwps_addr_t  aai_next;
    logic        aai_wrap;
    logic        locked;
    logic        is_prog;

    assign aai_next = q.aai_addr + `FWPS_AAI_STEP;
    assign aai_wrap = &q.aai_addr[`FWPS_ADDR_W-1:1];
    assign locked   = q.protect_lock_bit & ~q.wp_s2;
    assign is_prog  = (cmd_code == FWPS_BYTE) || (cmd_code == FWPS_AAI)
                   || (cmd_code == FWPS_SECT) || (cmd_code == FWPS_BLK32)
                   || (cmd_code == FWPS_BLK64) || (cmd_code == FWPS_CHIP);

    fwps_range_check u_cmd_chk (
        .op                 (cmd_code),
        .addr               (cmd_addr),
        .block_protect      (q.block_protect),
        .top_sector_lock    (q.top_sector_lock),
        .bottom_sector_lock (q.bottom_sector_lock),
        .hit                (cmd_hit)
    );

    // Looks one word ahead so auto-increment stops before protected space
    fwps_range_check u_aai_chk (
        .op                 (FWPS_AAI),
        .addr               (aai_next),
        .block_protect      (q.block_protect),
        .top_sector_lock    (q.top_sector_lock),
        .bottom_sector_lock (q.bottom_sector_lock),
        .hit                (next_hit)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d         = q;
        d.start   = 1'b0;
        d.refused = 1'b0;
        d.wp_s1   = wp_n;
        d.wp_s2   = q.wp_s1;
        case (q.st)
            FWPS_BUSY: begin
                // Commands arriving now are dropped; host must only poll
                if (op_done) begin
                    d.st = FWPS_IDLE;
                    if (!q.aai_mode) begin
                        d.write_enable_latch = 1'b0;
                    end else if (aai_wrap || next_hit) begin
                        d.aai_mode           = 1'b0;
                        d.write_enable_latch = 1'b0;
                    end
                end
            end
            FWPS_IDLE: begin
                if (cmd_valid) begin
                    case (cmd_code)
                        FWPS_WRITE_ENABLE_CMD: d.write_enable_latch = 1'b1;
                        FWPS_WRITE_DISABLE_CMD: begin
                            d.write_enable_latch = 1'b0;
                            d.aai_mode           = 1'b0;
                        end
                        FWPS_STATUS_WRITE_CMD: begin
                            d.write_enable_latch = 1'b0;
                            if (!locked) begin
                                d.protect_lock_bit = cmd_data[`FWPS_SM_BPL];
                                d.block_protect    =
                                    cmd_data[`FWPS_SM_BP_HI:`FWPS_SM_BP_LO];
                                if (cmd_data1_valid) begin
                                    d.top_sector_lock =
                                        cmd_data1[`FWPS_SL_TSP];
                                    d.bottom_sector_lock =
                                        cmd_data1[`FWPS_SL_BSP];
                                end
                            end
                        end
                        FWPS_AAI: begin
                            if (q.aai_mode) begin
                                d.start    = 1'b1;
                                d.op       = FWPS_AAI;
                                d.op_addr  = aai_next;
                                d.aai_addr = aai_next;
                                d.st       = FWPS_BUSY;
                            end else if (!q.write_enable_latch
                                         || cmd_hit) begin
                                d.refused = 1'b1;
                            end else begin
                                d.aai_mode = 1'b1;
                                d.aai_addr = {cmd_addr[`FWPS_ADDR_W-1:1],
                                              1'b0};
                                d.start    = 1'b1;
                                d.op       = FWPS_AAI;
                                d.op_addr  = d.aai_addr;
                                d.st       = FWPS_BUSY;
                            end
                        end
                        default: begin
                            if (is_prog) begin
                                if (!q.write_enable_latch || cmd_hit
                                    || q.aai_mode) begin
                                    d.refused = 1'b1;
                                end else begin
                                    d.start   = 1'b1;
                                    d.op      = cmd_code;
                                    d.op_addr = cmd_addr;
                                    d.st      = FWPS_BUSY;
                                end
                            end
                        end
                    endcase
                end
            end
            default: d.st = FWPS_IDLE;
        endcase
        // Reserved positions are never loaded, so they read zero
        d.stat_main = 8'h00;
        d.stat_main[`FWPS_SM_BUSY] = (d.st == FWPS_BUSY);
        d.stat_main[`FWPS_SM_WEL]  = d.write_enable_latch;
        d.stat_main[`FWPS_SM_BP_HI:`FWPS_SM_BP_LO] = d.block_protect;
        d.stat_main[`FWPS_SM_AAI]  = d.aai_mode;
        d.stat_main[`FWPS_SM_BPL]  = d.protect_lock_bit;
        d.stat_sect = 8'h00;
        d.stat_sect[`FWPS_SL_TSP] = d.top_sector_lock;
        d.stat_sect[`FWPS_SL_BSP] = d.bottom_sector_lock;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q                    <= '0;
            q.st                 <= FWPS_IDLE;
            q.op                 <= FWPS_NONE;
            q.block_protect      <= `FWPS_BP_RST;
            q.protect_lock_bit   <= `FWPS_BPL_RST;
            q.top_sector_lock    <= `FWPS_SL_RST;
            q.bottom_sector_lock <= `FWPS_SL_RST;
            q.stat_main          <= {4'h0, `FWPS_BP_RST, 2'h0};
        end else begin
            q <= d;
        end
    end

    assign status_main        = q.stat_main;
    assign sector_lock_status = q.stat_sect;
    assign op_start           = q.start;
    assign op_code            = q.op;
    assign op_addr            = q.op_addr;
    assign op_refused         = q.refused;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence idle_cmd(fwps_cmd_e c);
        q.st == FWPS_IDLE && cmd_valid && cmd_code == c;
    endsequence

    sequence prog_cmd;
        q.st == FWPS_IDLE && cmd_valid && is_prog && !q.aai_mode;
    endsequence

    status_write_cmd_lock_a: assert property (idle_cmd(FWPS_STATUS_WRITE_CMD) ##0 locked
        |=> $stable(q.block_protect) && $stable(q.protect_lock_bit)
            && $stable(sector_lock_status))
        else $error("locked status write changed protection");
    status_write_cmd_open_a: assert property (idle_cmd(FWPS_STATUS_WRITE_CMD) ##0 !locked
        |=> status_main[`FWPS_SM_BPL] == $past(cmd_data[`FWPS_SM_BPL]))
        else $error("unlocked status write not applied");
    busy_start_a: assert property (op_start
        |-> status_main[`FWPS_SM_BUSY] && !op_refused)
        else $error("busy not set with operation start");
    busy_done_a: assert property (status_main[0] && op_done
        |=> !status_main[0])
        else $error("busy stayed after completion");
    wel_gate_a: assert property (prog_cmd ##0 !q.write_enable_latch
        |=> op_refused && !op_start)
        else $error("program ran without write enable");
    wel_clear_a: assert property ((idle_cmd(FWPS_WRITE_DISABLE_CMD)
        or idle_cmd(FWPS_STATUS_WRITE_CMD)) |=> !status_main[`FWPS_SM_WEL])
        else $error("write enable latch not cleared");
    aai_rise_a: assert property ($rose(status_main[`FWPS_SM_AAI])
        |-> op_start && op_code == FWPS_AAI)
        else $error("auto-increment mode without start");
    chip_bp_a: assert property (idle_cmd(FWPS_CHIP)
        ##0 q.block_protect != 2'h0 |=> op_refused)
        else $error("chip erase ran with block protect set");
    full_prot_a: assert property (prog_cmd
        ##0 q.block_protect == 2'h3 |=> op_refused)
        else $error("program ran inside protected array");
    top_lock_a: assert property (prog_cmd ##0 q.top_sector_lock
        ##0 cmd_addr >= `FWPS_TOP_SECT_LO |=> op_refused)
        else $error("program ran in locked top sector");
    rsvd_zero_a: assert property ((status_main & 8'h30) == 8'h00
        && (sector_lock_status & 8'hF3) == 8'h00)
        else $error("reserved status bits not zero");
    refuse_idle_a: assert property (op_refused
        |-> !status_main[0] && !op_start)
        else $error("refused operation went busy");
    pwr_up_a: assert property (!$past(rstn)
        |-> status_main == 8'h0C && sector_lock_status == 8'h00)
        else $error("power-up status values wrong");

endmodule

`default_nettype wire

// >>> fwps_status_ctrl_unused_guard.sv
`default_nettype none
`default_nettype wire

// >>> fwps_array_model.sv
`default_nettype none

// Array timing stand-in: answers each launched operation with a done pulse,
// either promptly or slowly, so busy is seen both briefly and at length
module fwps_array_model (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic op_start,
    input  wire logic slow,
    output var  logic op_done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt;
    logic       run;

    always @(posedge core_clk) begin
        if (!rstn) begin
            run     <= 1'b0;
            cnt     <= 8'h00;
            op_done <= 1'b0;
        end else begin
            op_done <= 1'b0;
            if (op_start) begin
                run <= 1'b1;
                cnt <= slow ? 8'h28 : 8'h03;
            end else if (run) begin
                if (cnt == 8'h00) begin
                    op_done <= 1'b1;
                    run     <= 1'b0;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end
endmodule

`default_nettype wire

// >>> fwps_testbench.sv
`default_nettype none

module testbench;
    import fwps_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       wp_n = 1'b1;
    logic       cmd_valid = 1'b0;
    fwps_cmd_e  cmd_code = FWPS_NONE;
    fwps_addr_t cmd_addr = '0;
    logic [7:0] cmd_data = 8'h00;
    logic       cmd_data1_valid = 1'b0;
    logic [7:0] cmd_data1 = 8'h00;
    logic       op_done;
    logic       slow = 1'b0;
    logic [7:0] status_main;
    logic [7:0] sector_lock_status;
    logic       op_start;
    fwps_cmd_e  op_code;
    fwps_addr_t op_addr;
    logic       op_refused;
    int         mismatches = 0;
    int         comparisons = 0;
    int         cycles = 0;
    fwps_addr_t addrs [4] = '{18'h1FFFF, 18'h20000, 18'h2FFFF, 18'h30000};

    always #2.5 core_clk = ~core_clk;

    fwps_status_ctrl uut (
        .core_clk(core_clk), .rstn(rstn), .wp_n(wp_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_data1_valid(cmd_data1_valid),
        .cmd_data1(cmd_data1), .op_done(op_done),
        .status_main(status_main), .sector_lock_status(sector_lock_status),
        .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
        .op_refused(op_refused)
    );

    fwps_array_model array_i (
        .core_clk(core_clk), .rstn(rstn), .op_start(op_start),
        .slow(slow), .op_done(op_done)
    );

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [17:0] e,
                       input logic [17:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run needs a few hundred cycles; this only catches a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Command port access
    // ------------------------------------------------------------------
    task automatic do_reset();
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
    endtask

    // Outputs of the command are settled at the negedge this returns on
    task automatic cmd(input fwps_cmd_e c, input fwps_addr_t a = '0,
                       input logic [7:0] d0 = 8'h00,
                       input logic [7:0] d1 = 8'h00,
                       input logic v1 = 1'b0);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_addr = a;
        cmd_data = d0;
        cmd_data1 = d1;
        cmd_data1_valid = v1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_data1_valid = 1'b0;
    endtask

    // Only status is looked at while busy; no command is sent meanwhile
    task automatic wait_idle();
        int n;
        n = 0;
        while (status_main[0] !== 1'b0 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        chk("busy timeout", 0, status_main[0]);
    endtask

    task automatic status_write_cmd(input logic [7:0] d0, input logic [7:0] d1);
        cmd(FWPS_WRITE_ENABLE_CMD);
        cmd(FWPS_STATUS_WRITE_CMD, '0, d0, d1, 1'b1);
        chk("latch after status write", 0, status_main[1]);
    endtask

    task automatic prog(input fwps_cmd_e c, input fwps_addr_t a,
                        input logic ok);
        cmd(FWPS_WRITE_ENABLE_CMD);
        chk("latch set", 1, status_main[1]);
        cmd(c, a);
        chk("start", ok, op_start);
        chk("refused", !ok, op_refused);
        chk("busy", ok, status_main[0]);
        if (ok) begin
            chk("op code", c, op_code);
            if (c == FWPS_BYTE)
                chk("op addr", a, op_addr);
            wait_idle();
            chk("latch after op", 0, status_main[1]);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        chk("main at reset", 8'h0C, status_main);
        chk("sector at reset", 8'h00, sector_lock_status);
        cmd(FWPS_BYTE, 18'h00010);
        chk("no latch refused", 1, op_refused);
        chk("no latch busy", 0, status_main[0]);
        prog(FWPS_CHIP, '0, 1'b0);
        // Reserved bits written as ones must stay zero
        status_write_cmd(8'h30, 8'hF3);
        chk("main reserved", 8'h00, status_main);
        chk("sector reserved", 8'h00, sector_lock_status);
        for (int b = 3; b >= 0; b--) begin
            status_write_cmd(8'(b << 2), 8'h00);
            chk("protect field", 8'(b << 2), status_main);
            for (int i = 0; i < 4; i++)
                prog(FWPS_BYTE, addrs[i], !((b == 3) ||
                     (b == 2 && addrs[i] >= 18'h20000) ||
                     (b == 1 && addrs[i] >= 18'h30000)));
        end
        slow = 1'b1;
        status_write_cmd(8'h00, 8'h04);
        chk("top lock", 8'h04, sector_lock_status);
        prog(FWPS_BYTE, 18'h3F000, 1'b0);
        prog(FWPS_SECT, 18'h3F000, 1'b0);
        prog(FWPS_BLK64, 18'h30000, 1'b0);
        prog(FWPS_BYTE, 18'h3EFFF, 1'b1);
        status_write_cmd(8'h00, 8'h08);
        chk("bottom lock", 8'h08, sector_lock_status);
        prog(FWPS_BYTE, 18'h00FFF, 1'b0);
        prog(FWPS_BLK32, 18'h00000, 1'b0);
        prog(FWPS_CHIP, '0, 1'b0);
        prog(FWPS_BYTE, 18'h01000, 1'b1);
        status_write_cmd(8'h00, 8'h00);
        slow = 1'b0;
        prog(FWPS_SECT, 18'h05000, 1'b1);
        prog(FWPS_BLK32, 18'h08000, 1'b1);
        prog(FWPS_BLK64, 18'h10000, 1'b1);
        prog(FWPS_CHIP, '0, 1'b1);
        // Auto-increment: latch survives each word, ends on write-disable
        cmd(FWPS_WRITE_ENABLE_CMD);
        cmd(FWPS_AAI, 18'h10001);
        chk("aai addr", 18'h10000, op_addr);
        chk("aai busy", 8'h43, status_main);
        wait_idle();
        chk("aai idle", 8'h42, status_main);
        cmd(FWPS_AAI, 18'h00000);
        chk("aai next", 18'h10002, op_addr);
        wait_idle();
        cmd(FWPS_WRITE_DISABLE_CMD);
        chk("aai end", 8'h00, status_main);
        // Auto-increment stops before the protected top quarter
        status_write_cmd(8'h04, 8'h00);
        cmd(FWPS_WRITE_ENABLE_CMD);
        cmd(FWPS_AAI, 18'h2FFFE);
        chk("aai last word", 18'h2FFFE, op_addr);
        wait_idle();
        chk("aai stop", 8'h04, status_main);
        cmd(FWPS_AAI, 18'h00000);
        chk("aai no latch", 1, op_refused);
        // Lock with pin low freezes protection fields
        status_write_cmd(8'h80, 8'h00);
        wp_n = 1'b0;
        repeat (3) @(negedge core_clk);
        status_write_cmd(8'h0C, 8'h0C);
        chk("locked main", 8'h80, status_main);
        chk("locked sector", 8'h00, sector_lock_status);
        wp_n = 1'b1;
        repeat (3) @(negedge core_clk);
        status_write_cmd(8'h84, 8'h08);
        chk("pin high main", 8'h84, status_main);
        chk("pin high sector", 8'h08, sector_lock_status);
        // Single-byte status write leaves the sector locks alone
        cmd(FWPS_WRITE_ENABLE_CMD);
        cmd(FWPS_STATUS_WRITE_CMD, '0, 8'h80);
        chk("one byte main", 8'h80, status_main);
        chk("one byte sector", 8'h08, sector_lock_status);
        wp_n = 1'b0;
        do_reset();
        chk("main re-reset", 8'h0C, status_main);
        chk("sector re-reset", 8'h00, sector_lock_status);
        status_write_cmd(8'h00, 8'h04);
        chk("unlocked main", 8'h00, status_main);
        final_report();
    end
endmodule

`default_nettype wire
